// [hdl/pps_cell_sampler.sv]
/*
 * Periodic cell sampler: latches per-cell comparator flags every period.
 * Assumes flags are already synchronised; cell count strap is static.
 */
`timescale 1ns/10ps
`include "pps_cfg.svh"
module pps_cell_sampler #(
  parameter int CELLS = `PPS_MAX_CELLS,
  parameter logic [23:0] PERIOD = 24'(`PPS_SAMPLE_CYC)
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Raw per-cell flags and cell count select.
  input wire logic [CELLS-1:0] ov,
  input wire logic [CELLS-1:0] uv,
  input wire logic [CELLS-1:0] ce,
  input wire logic four_cells,
  // Sampled results.
  pps_flags_if.src flg
);
  typedef struct packed {
    logic [23:0] cnt;
    logic ov_any;
    logic uv_any;
    logic ce_all;
    logic tick;
  } pps_smp_s;
  pps_smp_s st_q, st_d;
  logic [CELLS-1:0] en;

  genvar g;
  generate
    for (g = 0; g < CELLS; g++) begin : g_en
      assign en[g] = (g < `PPS_CELLS_LOW) ? 1'b1 : four_cells;
    end
  endgenerate

  always_comb begin
    st_d = st_q;
    st_d.tick = 1'b0;
    if (st_q.cnt >= PERIOD - 24'h000001) begin
      st_d.cnt = 24'h000000;
      st_d.tick = 1'b1;
      st_d.ov_any = |(ov & en);
      st_d.uv_any = |(uv & en);
      st_d.ce_all = &(ce | ~en);
    end else begin
      st_d.cnt = st_q.cnt + 24'h000001;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign flg.ov_any = st_q.ov_any;
  assign flg.uv_any = st_q.uv_any;
  assign flg.ce_all = st_q.ce_all;
  assign flg.sample_tick = st_q.tick;

  chk_sample_gap: assert property (@(posedge clk) disable iff (!rst_b)
    st_q.tick |=> !st_q.tick [*2])
    else $error("Sample ticks too close together.");
endmodule : pps_cell_sampler

// [hdl/pps_cfg.svh]
/*
 * Timing, width and cell count constants of the pack protection supervisor.
 * Assumes a 10 MHz system clock; times are converted to cycles here.
 */
`ifndef PPS_CFG_SVH
`define PPS_CFG_SVH

`define PPS_CLK_HZ 10000000
`define PPS_SAMPLE_MS 40
// Divide first so that the long delays stay inside 32-bit arithmetic.
`define PPS_SAMPLE_CYC (`PPS_SAMPLE_MS * (`PPS_CLK_HZ / 1000))
`define PPS_OCD_MS 12
`define PPS_OCD_CYC (`PPS_OCD_MS * (`PPS_CLK_HZ / 1000))
`define PPS_OVD_MS 950
`define PPS_OVD_CYC (`PPS_OVD_MS * (`PPS_CLK_HZ / 1000))
`define PPS_UVD_MS 950
`define PPS_UVD_CYC (`PPS_UVD_MS * (`PPS_CLK_HZ / 1000))
`define PPS_CNT_W 24
`define PPS_MAX_CELLS 4
`define PPS_CELLS_LOW 3

`endif

// [hdl/pps_delay_timer.sv]
/*
 * Fault persistence timer: trips after the flag holds for LIMIT cycles.
 * Assumes the fault flag is synchronous to the clock.
 */
`timescale 1ns/10ps
`include "pps_cfg.svh"
module pps_delay_timer #(
  parameter logic [23:0] LIMIT = 24'h00000A
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Fault flag and forced clear.
  input wire logic fault,
  input wire logic hold,
  // Expiry level.
  output logic expired
);
  typedef struct packed {
    logic [23:0] cnt;
    logic done;
  } pps_tmr_s;
  pps_tmr_s st_q, st_d;

  always_comb begin
    st_d = st_q;
    // restart on drop. Early clearing never trips.
    if (hold || !fault) begin
      st_d.cnt = 24'h000000;
      st_d.done = 1'b0;
    end else if (st_q.cnt >= LIMIT - 24'h000001) begin
      st_d.done = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt + 24'h000001;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign expired = st_q.done;

  chk_trip_needs_fault: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(expired) |-> $past(fault) && !$past(hold))
    else $error("Timer tripped without a held fault.");
endmodule : pps_delay_timer

// [hdl/pps_flags_if.sv]
/*
 * Interface carrying qualified cell flags from the sampler to the core.
 * Assumes both ends share CLK_SYS.
 */
`timescale 1ns/10ps
interface pps_flags_if;
  logic ov_any;
  logic uv_any;
  logic ce_all;
  logic sample_tick;
  modport src (output ov_any, output uv_any, output ce_all,
    output sample_tick);
  modport dst (input ov_any, input uv_any, input ce_all,
    input sample_tick);
endinterface : pps_flags_if

// [hdl/pps_pkg.sv]
/*
 * Types shared by the pack protection supervisor modules.
 * Assumes the constants header is included where counts are needed.
 */
package pps_pkg;

  typedef enum logic [1:0] {
    PPS_SLEEP,
    PPS_ACTIVE
  } pps_mode_e;

  typedef logic [23:0] pps_cnt_t;

endpackage : pps_pkg

// [hdl/pps_supervisor.sv]
/*
 * Pack protection supervisor top: sleep/wake, fault qualification and
 * the charge and discharge block outputs for a 3 or 4 cell pack.
 * Assumes comparator flags and straps arrive as digital pins from the
 * analog front end and are asynchronous to CLK_SYS.
 */
// Notes on behaviour
// - Sample cell comparisons every 40 ms.
// - Overcurrent and charge detect watched continuously.
// - Power-up enters sleep, discharge blocked.
// - Only charge detect wakes from sleep.
// - Charge detect releases the discharge block.
// - Held undervoltage blocks discharge, then sleeps.
// - Held overvoltage blocks charge until enable.
// - Floating cell input counts as overvoltage.
// - Charge re-enabled when all cells below enable.
// - Overcurrent in discharge direction, after delay.
// - Overcurrent block clears when comparisons false.
// - Output states per fault condition.
// - Cell select strap picks three or four.
// - Pack disable forces both outputs high.
// - Pack disable holds overcurrent timer reset.
// - Pack disable release resumes normal evaluation.
// - Fault other than floating input must persist whole delay to trip.
// - Delays default 12 ms and 950 ms.
// - Sampling adds latency; overcurrent is prompt.
// - Recheck cells when undervoltage delay expires.
// - Outputs are active-high blocks.
`timescale 1ns/10ps
`include "pps_cfg.svh"
module pps_supervisor #(
  parameter int CELLS = `PPS_MAX_CELLS,
  parameter logic [23:0] SAMPLE_CYC = 24'(`PPS_SAMPLE_CYC),
  parameter logic [23:0] OCD_CYC = 24'(`PPS_OCD_CYC),
  parameter logic [23:0] OVD_CYC = 24'(`PPS_OVD_CYC),
  parameter logic [23:0] UVD_CYC = 24'(`PPS_UVD_CYC)
) (
  // Clock and reset.
  input wire logic CLK_SYS,
  input wire logic RST_B,
  // Per-cell comparator flags.
  input wire logic [CELLS-1:0] CELL_OV,
  input wire logic [CELLS-1:0] CELL_UV,
  input wire logic [CELLS-1:0] CELL_CE,
  input wire logic CELL_FLOAT,
  // Current sense comparator flags.
  input wire logic LOW_SIDE_OC,
  input wire logic HIGH_SIDE_OC,
  input wire logic LOW_SIDE_CHG_DET,
  input wire logic HIGH_SIDE_CHG_DET,
  // Straps and external disable.
  input wire logic CELL_COUNT_SEL,
  input wire logic PACK_DISABLE_IN,
  // FET control outputs and state.
  output logic CHARGE_BLOCK_OUT,
  output logic DISCHARGE_BLOCK_OUT,
  output logic SLEEP_OUT
);
  localparam int NS = 3 * CELLS + 6;

  typedef struct packed {
    logic [NS-1:0] s1;
    logic [NS-1:0] s2;
    pps_pkg::pps_mode_e mode;
    logic ov_lat;
    logic oc_lat;
    logic charge_block_out;
    logic discharge_block_out;
    logic slp;
  } pps_top_s;
  pps_top_s st_q, st_d;

  logic [NS-1:0] raw;
  logic [CELLS-1:0] ov_s, uv_s, ce_s;
  logic flt_s, oc_s, cd_s, sel_s, dis_s;
  logic ovd_exp, uvd_exp, ocd_exp, ov_fault;
  pps_flags_if flg ();

  // Overvoltage and charge enable travel apart; merging them would read
  // a healthy cell below the enable threshold as overvoltage.
  assign raw = {CELL_CE, CELL_OV, CELL_UV, CELL_FLOAT, LOW_SIDE_OC,
    HIGH_SIDE_OC, LOW_SIDE_CHG_DET | HIGH_SIDE_CHG_DET, CELL_COUNT_SEL,
    PACK_DISABLE_IN};
  assign ov_s = st_q.s2[2*CELLS+5 -: CELLS];
  assign uv_s = st_q.s2[CELLS+5 -: CELLS];
  assign flt_s = st_q.s2[5];
  assign oc_s = st_q.s2[4] | st_q.s2[3];
  assign cd_s = st_q.s2[2];
  assign sel_s = st_q.s2[1];
  assign dis_s = st_q.s2[0];

  pps_cell_sampler #(.CELLS(CELLS), .PERIOD(SAMPLE_CYC)) u_smp (
    .clk(CLK_SYS),
    .rst_b(RST_B),
    .ov(ov_s),
    .uv(uv_s),
    .ce(ce_s),
    .four_cells(sel_s),
    .flg(flg.src)
  );

  assign ov_fault = flg.ov_any | flt_s;

  pps_delay_timer #(.LIMIT(OVD_CYC)) u_ovd (
    .clk(CLK_SYS),
    .rst_b(RST_B),
    .fault(ov_fault),
    .hold(st_q.ov_lat),
    .expired(ovd_exp)
  );
  pps_delay_timer #(.LIMIT(UVD_CYC)) u_uvd (
    .clk(CLK_SYS),
    .rst_b(RST_B),
    .fault(flg.uv_any),
    .hold(st_q.slp),
    .expired(uvd_exp)
  );
  pps_delay_timer #(.LIMIT(OCD_CYC)) u_ocd (
    .clk(CLK_SYS),
    .rst_b(RST_B),
    .fault(oc_s),
    .hold(dis_s | st_q.oc_lat),
    .expired(ocd_exp)
  );

  always_comb begin
    st_d = st_q;
    st_d.s1 = raw;
    st_d.s2 = st_q.s1;
    case (st_q.mode)
      pps_pkg::PPS_SLEEP: begin
        if (cd_s) begin
          st_d.mode = pps_pkg::PPS_ACTIVE;
        end
      end
      pps_pkg::PPS_ACTIVE: begin
        if (ovd_exp || flt_s) begin
          st_d.ov_lat = 1'b1;
        end else if (st_q.ov_lat && flg.sample_tick && flg.ce_all) begin
          st_d.ov_lat = 1'b0;
        end
        if (ocd_exp) begin
          st_d.oc_lat = 1'b1;
        end else if (!oc_s) begin
          st_d.oc_lat = 1'b0;
        end
        if (uvd_exp && flg.uv_any) begin
          st_d.mode = pps_pkg::PPS_SLEEP;
          st_d.oc_lat = 1'b0;
        end
      end
      default: begin
        st_d.mode = pps_pkg::PPS_SLEEP;
      end
    endcase
    st_d.slp = (st_d.mode == pps_pkg::PPS_SLEEP);
    st_d.charge_block_out = st_d.ov_lat;
    st_d.discharge_block_out = st_d.slp | st_d.oc_lat;
    if (dis_s) begin
      st_d.charge_block_out = 1'b1;
      st_d.discharge_block_out = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      st_q <= '0;
      st_q.mode <= pps_pkg::PPS_SLEEP;
      st_q.discharge_block_out <= 1'b1;
      st_q.slp <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign ce_s = st_q.s2[NS-1 -: CELLS];
  assign CHARGE_BLOCK_OUT = st_q.charge_block_out;
  assign DISCHARGE_BLOCK_OUT = st_q.discharge_block_out;
  assign SLEEP_OUT = st_q.slp;

  chk_disable_both: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    dis_s |=> CHARGE_BLOCK_OUT && DISCHARGE_BLOCK_OUT)
    else $error("Pack disable did not block both paths.");
  chk_sleep_blocks: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    SLEEP_OUT |-> DISCHARGE_BLOCK_OUT)
    else $error("Sleep without discharge block.");
  chk_wake_cause: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    $fell(SLEEP_OUT) |-> $past(cd_s))
    else $error("Woke without charge detect.");
  chk_uv_sleep: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    (st_q.mode == pps_pkg::PPS_ACTIVE && uvd_exp && flg.uv_any)
    |=> SLEEP_OUT && DISCHARGE_BLOCK_OUT)
    else $error("Undervoltage expiry did not sleep.");
  chk_ov_hold: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    $fell(st_q.ov_lat) |-> $past(flg.ce_all))
    else $error("Charge re-enabled without charge enable.");
  chk_oc_release: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    $fell(st_q.oc_lat) |-> !$past(oc_s) || $past(uvd_exp))
    else $error("Overcurrent block dropped while fault present.");
  chk_oc_hold_dis: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    dis_s |=> !ocd_exp)
    else $error("Overcurrent timer ran during disable.");
  chk_chg_table: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    !dis_s && !st_d.ov_lat |=> !CHARGE_BLOCK_OUT)
    else $error("Charge block without overvoltage.");

  chk_ov_blocks: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    st_q.ov_lat |-> CHARGE_BLOCK_OUT)
    else $error("Overvoltage latch without charge block.");
  chk_oc_blocks: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    st_q.oc_lat |-> DISCHARGE_BLOCK_OUT)
    else $error("Overcurrent latch without discharge block.");
  chk_dis_release: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    !dis_s && !st_d.slp && !st_d.oc_lat |=> !DISCHARGE_BLOCK_OUT)
    else $error("Discharge blocked with no cause.");
  chk_sleep_stays: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    SLEEP_OUT && !cd_s |=> SLEEP_OUT)
    else $error("Left sleep without charge detect.");

  cov_uv_sleep: cover property (@(posedge CLK_SYS) disable iff (!RST_B)
    $rose(SLEEP_OUT));
  cov_wake: cover property (@(posedge CLK_SYS) disable iff (!RST_B)
    $fell(SLEEP_OUT));
  cov_ov_trip: cover property (@(posedge CLK_SYS) disable iff (!RST_B)
    $rose(CHARGE_BLOCK_OUT) && !dis_s);
  cov_oc_trip: cover property (@(posedge CLK_SYS) disable iff (!RST_B)
    $rose(st_q.oc_lat));
endmodule : pps_supervisor

// [testbench/pps_front_end_model.sv]
/*
 * Model of the cells and sense comparators facing the supervisor.
 * Assumes tasks are called from the bench; flags change at falling edges.
 */
`timescale 1ns/10ps
module pps_front_end_model (
  // Clock.
  input wire logic clk,
  // Cell flags.
  output logic [3:0] cell_ov,
  output logic [3:0] cell_uv,
  output logic [3:0] cell_ce,
  output logic cell_float,
  // Current flags: low and high overcurrent, low and high charge detect.
  output logic [3:0] cur
);
  logic [3:0] hot;
  // A cell above overvoltage is also above charge enable, never both.
  assign cell_ov = hot;
  assign cell_ce = ~hot;
  initial begin
    hot = 4'h0;
    cell_uv = 4'h0;
    cell_float = 1'b0;
    cur = 4'h0;
  end
  task automatic set_cells(input logic [3:0] h, input logic [3:0] f);
    @(negedge clk);
    hot = h;
    cell_uv = f;
  endtask : set_cells
  task automatic set_float(input logic v);
    @(negedge clk);
    cell_float = v;
  endtask : set_float
  task automatic set_current(input logic [3:0] v);
    @(negedge clk);
    cur = v;
  endtask : set_current
endmodule : pps_front_end_model

// [testbench/tb_pack_protection_supervisor.sv]
/*
 * Self-checking bench for the supervisor with shortened delays.
 * Assumes the front end model drives every comparator flag.
 */
`timescale 1ns/10ps
module tb_pack_protection_supervisor;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic sel = 1'b0;
  logic dis = 1'b0;
  logic [3:0] ov, uv, ce, cur;
  logic flt, charge_block_out, discharge_block_out, slp;
  int mismatches = 0;
  int checks = 0;
  int i;

  always #50 clk_sys = ~clk_sys;

  pps_front_end_model model_u (.clk(clk_sys), .cell_ov(ov), .cell_uv(uv),
    .cell_ce(ce), .cell_float(flt), .cur(cur));

  pps_supervisor #(.CELLS(4), .SAMPLE_CYC(24'h000014),
    .OCD_CYC(24'h000032), .OVD_CYC(24'h000064), .UVD_CYC(24'h000064)
  ) dut_u (.CLK_SYS(clk_sys), .RST_B(rst_b), .CELL_OV(ov), .CELL_UV(uv),
    .CELL_CE(ce), .CELL_FLOAT(flt), .LOW_SIDE_OC(cur[3]),
    .HIGH_SIDE_OC(cur[2]), .LOW_SIDE_CHG_DET(cur[1]),
    .HIGH_SIDE_CHG_DET(cur[0]), .CELL_COUNT_SEL(sel),
    .PACK_DISABLE_IN(dis), .CHARGE_BLOCK_OUT(charge_block_out),
    .DISCHARGE_BLOCK_OUT(discharge_block_out), .SLEEP_OUT(slp));

  // State order is charge block, discharge block, sleep.
  task automatic compare(input string what, input logic [2:0] exp,
    input logic [2:0] msk);
    checks++;
    if (({charge_block_out, discharge_block_out, slp} & msk) !== exp) begin
      mismatches++;
      $display("mismatch %s expected %b seen %b", what, exp,
        {charge_block_out, discharge_block_out, slp});
    end
  endtask : compare
  task automatic wait_for(input string what, input logic [2:0] exp,
    input int lim, input logic [2:0] msk = 3'h7);
    int n;
    n = 0;
    while ((({charge_block_out, discharge_block_out, slp} & msk) !== exp) && n < lim) begin
      @(negedge clk_sys);
      n++;
    end
    compare(what, exp, msk);
  endtask : wait_for
  // Stops at the first deviation so the compare reports it.
  task automatic hold_for(input string what, input logic [2:0] exp,
    input int cyc);
    for (int n = 0; n < cyc; n++) begin
      @(negedge clk_sys);
      if ({charge_block_out, discharge_block_out, slp} !== exp) break;
    end
    compare(what, exp, 3'h7);
  endtask : hold_for
  task automatic restart(input logic four);
    @(negedge clk_sys);
    rst_b = 1'b0;
    sel = four;
    repeat (8) @(negedge clk_sys);
    rst_b = 1'b1;
  endtask : restart
  task automatic wake(input logic [3:0] det);
    model_u.set_current(det);
    wait_for("wake", 3'h0, 6);
    model_u.set_current(4'h0);
  endtask : wake
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    $display("mismatch watchdog expected finish seen hang");
    complete_run();
  end

  initial begin
    restart(1'b0);
    @(negedge clk_sys);
    compare("reset state", 3'h3, 3'h7);
    model_u.set_current(4'h8);
    model_u.set_cells(4'h0, 4'h1);
    hold_for("asleep", 3'h3, 150);
    model_u.set_current(4'h0);
    model_u.set_cells(4'h0, 4'h0);
    wake(4'h1);
    model_u.set_cells(4'h8, 4'h0);
    hold_for("unused cell", 3'h0, 200);
    model_u.set_cells(4'h0, 4'h0);
    $display("test sleep and three cells done");
    restart(1'b1);
    wake(4'h2);
    // Too short a fault must not trip.
    model_u.set_cells(4'h8, 4'h0);
    repeat (60) @(negedge clk_sys);
    model_u.set_cells(4'h0, 4'h0);
    hold_for("ov short", 3'h0, 200);
    model_u.set_cells(4'h8, 4'h0);
    hold_for("ov early", 3'h0, 95);
    wait_for("ov trip", 3'h4, 40);
    model_u.set_cells(4'h0, 4'h0);
    wait_for("ov release", 3'h0, 30);
    $display("test overvoltage done");
    for (i = 0; i < 2; i++) begin
      model_u.set_current(i == 0 ? 4'h8 : 4'h4);
      hold_for("oc early", 3'h0, 40);
      wait_for("oc trip", 3'h2, 20);
      model_u.set_current(4'h0);
      wait_for("oc clear", 3'h0, 6);
    end
    $display("test overcurrent done");
    model_u.set_current(4'h8);
    dis = 1'b1;
    wait_for("disable", 3'h6, 4);
    hold_for("disable hold", 3'h6, 120);
    @(negedge clk_sys);
    dis = 1'b0;
    wait_for("resume", 3'h0, 6);
    hold_for("oc restart", 3'h0, 35);
    wait_for("oc after", 3'h2, 30);
    model_u.set_current(4'h0);
    wait_for("oc clear", 3'h0, 6);
    $display("test pack disable done");
    model_u.set_float(1'b1);
    wait_for("float", 3'h4, 6, 3'h4);
    model_u.set_float(1'b0);
    wait_for("float release", 3'h0, 30);
    $display("test floating input done");
    model_u.set_cells(4'h0, 4'h4);
    hold_for("uv early", 3'h0, 95);
    wait_for("uv sleep", 3'h3, 40);
    model_u.set_cells(4'h0, 4'h0);
    wake(4'h1);
    $display("test undervoltage done");
    complete_run();
  end
endmodule : tb_pack_protection_supervisor
